//--- design/chps_pkg.sv
// chps_pkg: constants and types shared by the carriage home and paper sense logic
// assumes a single 20 MHz clock and synchronous active-low reset
package chps_pkg;
  localparam int          CLK_HZ        = 20000000;
  localparam int          STEP_US       = 1000;
  localparam int          STEP_CYC      = (CLK_HZ / 1000000) * STEP_US;
  localparam int          NOZZLES       = 56;
  localparam logic [5:0]  NOZZLE_FIRST  = 6'h01;
  localparam logic [5:0]  NOZZLE_LAST   = 6'h38;
  localparam int          CNT_W         = 16;
  localparam logic [15:0] NUDGE_STEPS   = 16'h0010;
  localparam logic [15:0] HIGH_MAX      = 16'h0200;
  localparam logic [15:0] RIGHT_MAX     = 16'h1000;
  localparam logic [15:0] JAM_STEPS     = 16'h0800;
  localparam logic [15:0] CNT_ZERO      = 16'h0000;
  localparam logic [15:0] CNT_ONE       = 16'h0001;
  localparam logic [1:0]  SYNC_ZERO     = 2'h0;

  typedef enum logic [1:0] {
    CHPS_CM_STOP  = 2'b00,
    CHPS_CM_LEFT  = 2'b01,
    CHPS_CM_RIGHT = 2'b10
  } chps_cmove_e;

  // 3-stage sample with agreement of stages 2 and 3
  function automatic logic chps_agree(input logic [2:0] s, input logic prev);
    return (s[1] == s[2]) ? s[2] : prev;
  endfunction
endpackage

//--- design/chps_step_if.sv
// chps_step_if: step pacing handshake between the sequencer and step timer
// assumes both ends share the block clock
`timescale 1ns/1ps
interface chps_step_if;
  logic run;
  logic tick;
  modport ctrl  (output run, input tick);
  modport timer (input run, output tick);
endinterface

//--- design/chps_step_timer.sv
// chps_step_timer: one-cycle step pulse every STEP_CYC clocks while run
// assumes run from same-clock logic
`timescale 1ns/1ps
module chps_step_timer
  import chps_pkg::*;
(
  input  wire logic  clock,
  input  wire logic  resetn,
  chps_step_if.timer stp
);
  typedef struct packed {
    logic [CNT_W-1:0] cnt;
    logic             tick;
  } chps_tmr_s;

  chps_tmr_s st_q;
  chps_tmr_s st_d;

  always_comb begin
    st_d      = st_q;
    st_d.tick = 1'b0;
    if (!stp.run) begin
      st_d.cnt = CNT_ZERO;
    end else if (st_q.cnt == CNT_W'(STEP_CYC - 1)) begin
      st_d.cnt  = CNT_ZERO;
      st_d.tick = 1'b1;
    end else begin
      st_d.cnt = st_q.cnt + CNT_ONE;
    end
  end

  always_ff @(posedge clock) begin
    if (!resetn) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign stp.tick = st_q.tick;
endmodule

//--- design/chps_home_paper.sv
// chps_home_paper: paper-in sensing for tray feed and carriage home search
// assumes sensor pins are asynchronous; motor drivers take step pulses
//
// Operation
// [R1] job start, bypass empty, tray loaded: run feed motor to pull a sheet
// [R2] during tray feed, paper sensor high-to-low marks the leading edge
// [R3] no high-to-low within jam timeout after feed start declares a jam
// [R4] while sheet exits, paper sensor low-to-high marks the trailing edge
// [R5] home sensor high means slit blocks path, low means path open
// [R6] home reads low at home; high while crossing slit leftward
// [R7] search starts with a small leftward move then samples home sensor
// [R8] sample low: go right through low-high, home at next high-low
// [R9] sample high: near home, go right, home at first high-low
// [R10] sensor high too long: flag fault and stop carriage
// [R11] sensor stuck low: travel right to frame, then stop motor
// [R12] nozzle test lines ordered left to right, nozzle 1 to 56
// [R13] jam timeout is a step count; expiry flags jam, stops feed
// [R14] rightward travel bounded; overrun flags stuck-low fault, halts
`timescale 1ns/1ps
module chps_home_paper
  import chps_pkg::*;
(
  input  wire logic              clock,
  input  wire logic              resetn,
  input  wire logic              jobStart,
  input  wire logic              bypassPresent,
  input  wire logic              trayLoaded,
  input  wire logic              sheetEject,
  input  wire logic              homeStart,
  input  wire logic              nozzleTestStart,
  input  wire logic              paperSense,
  input  wire logic              homeSense,
  output logic                   feedRun,
  output logic                   feedStep,
  output logic                   leadEdge,
  output logic                   trailEdge,
  output logic                   paperJam,
  output logic                   carriageStep,
  output chps_pkg::chps_cmove_e  carriageDir,
  output logic                   homeFound,
  output logic                   homeBusy,
  output logic                   homeStuckHigh,
  output logic                   homeStuckLow,
  output logic                   nozzleFire,
  output logic [5:0]             nozzleIndex
);
  import chps_pkg::*;

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    CHPS_PF_IDLE  = 2'b00,
    CHPS_PF_FEED  = 2'b01,
    CHPS_PF_HOLD  = 2'b10,
    CHPS_PF_EXIT  = 2'b11
  } chps_pfeed_e;

  typedef enum logic [2:0] {
    CHPS_HS_IDLE  = 3'b000,
    CHPS_HS_NUDGE = 3'b001,
    CHPS_HS_FIND  = 3'b010,
    CHPS_HS_CROSS = 3'b011,
    CHPS_HS_DONE  = 3'b100,
    CHPS_HS_FAULT = 3'b101
  } chps_hstate_e;

  typedef struct packed {
    logic [2:0]       paperSync;
    logic [2:0]       homeSync;
    logic             paperLvl;
    logic             homeLvl;
    chps_pfeed_e      pf;
    logic [CNT_W-1:0] jamCnt;
    logic             leadEdge;
    logic             trailEdge;
    logic             paperJam;
    chps_hstate_e     hs;
    logic [CNT_W-1:0] moveCnt;
    logic [CNT_W-1:0] highCnt;
    logic             homeFound;
    logic             stuckHigh;
    logic             stuckLow;
    logic             nozBusy;
    logic [5:0]       nozIdx;
    logic             nozFire;
  } chps_state_s;

  chps_state_s st_q;
  chps_state_s st_d;

  chps_step_if stp ();

  chps_step_timer u_timer (
    .clock  (clock),
    .resetn (resetn),
    .stp    (stp)
  );

  logic paperNew;
  logic homeNew;

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    st_d           = st_q;
    st_d.leadEdge  = 1'b0;
    st_d.trailEdge = 1'b0;
    st_d.nozFire   = 1'b0;
    st_d.paperSync = {st_q.paperSync[1:0], paperSense};
    st_d.homeSync  = {st_q.homeSync[1:0], homeSense};
    paperNew       = chps_agree(st_q.paperSync, st_q.paperLvl);
    // high = slit blocks the beam, low = beam open
    homeNew        = chps_agree(st_q.homeSync, st_q.homeLvl); // [R5]
    st_d.paperLvl  = paperNew;
    st_d.homeLvl   = homeNew;

    case (st_q.pf)
      CHPS_PF_IDLE: begin
        if (jobStart && !bypassPresent && trayLoaded) begin // [R1]
          st_d.pf       = CHPS_PF_FEED;
          st_d.jamCnt   = CNT_ZERO;
          st_d.paperJam = 1'b0;
        end
      end
      CHPS_PF_FEED: begin
        if (st_q.paperLvl && !paperNew) begin // [R2]
          st_d.leadEdge = 1'b1;
          st_d.pf       = CHPS_PF_HOLD;
        end else if (st_q.jamCnt >= JAM_STEPS) begin // [R3] [R13]
          st_d.paperJam = 1'b1;
          st_d.pf       = CHPS_PF_IDLE;
        end else if (stp.tick) begin
          st_d.jamCnt = st_q.jamCnt + CNT_ONE;
        end
      end
      CHPS_PF_HOLD: begin
        if (sheetEject) begin
          st_d.pf = CHPS_PF_EXIT;
        end
      end
      CHPS_PF_EXIT: begin
        if (!st_q.paperLvl && paperNew) begin // [R4]
          st_d.trailEdge = 1'b1;
          st_d.pf        = CHPS_PF_IDLE;
        end
      end
      default: st_d.pf = CHPS_PF_IDLE;
    endcase

    // long high run is never normal; counted in steps while moving
    if (!st_q.homeLvl) begin
      st_d.highCnt = CNT_ZERO;
    end else if (stp.tick && homeBusy) begin
      st_d.highCnt = st_q.highCnt + CNT_ONE;
    end

    case (st_q.hs)
      CHPS_HS_IDLE: begin
        if (homeStart) begin
          st_d.hs        = CHPS_HS_NUDGE;
          st_d.moveCnt   = CNT_ZERO;
          st_d.highCnt   = CNT_ZERO;
          st_d.homeFound = 1'b0;
          st_d.stuckHigh = 1'b0;
          st_d.stuckLow  = 1'b0;
        end
      end
      CHPS_HS_NUDGE: begin
        if (stp.tick) begin
          st_d.moveCnt = st_q.moveCnt + CNT_ONE;
        end
        if (st_q.moveCnt >= NUDGE_STEPS) begin // [R7]
          st_d.moveCnt = CNT_ZERO;
          // low: left of slit; high: inside slit, near home
          st_d.hs = st_q.homeLvl ? CHPS_HS_CROSS : CHPS_HS_FIND; // [R8] [R9]
        end
      end
      CHPS_HS_FIND: begin
        if (homeNew) begin // [R8]
          st_d.hs = CHPS_HS_CROSS;
        end
      end
      CHPS_HS_CROSS: begin
        if (st_q.homeLvl && !homeNew) begin // [R6] [R8] [R9]
          st_d.hs        = CHPS_HS_DONE;
          st_d.homeFound = 1'b1;
        end
      end
      default: begin
        if (homeStart) begin
          st_d.hs = CHPS_HS_IDLE;
        end
      end
    endcase

    if (homeBusy && st_q.highCnt >= HIGH_MAX) begin // [R10]
      st_d.hs        = CHPS_HS_FAULT;
      st_d.stuckHigh = 1'b1;
    end else if ((st_q.hs == CHPS_HS_FIND || st_q.hs == CHPS_HS_CROSS)
                 && stp.tick) begin
      st_d.moveCnt = st_q.moveCnt + CNT_ONE;
      // no home edge before the frame stop: stuck-low
      if (st_q.moveCnt >= RIGHT_MAX) begin // [R11] [R14]
        st_d.hs       = CHPS_HS_FAULT;
        st_d.stuckLow = 1'b1;
      end
    end

    // one line per nozzle, fired in order 1..56 left to right
    if (!st_q.nozBusy) begin
      if (nozzleTestStart) begin
        st_d.nozBusy = 1'b1;
        st_d.nozIdx  = NOZZLE_FIRST;
      end
    end else if (st_q.nozFire) begin // [R12]
      // advance only after the pulse, so each fire carries its own index
      if (st_q.nozIdx == NOZZLE_LAST) begin
        st_d.nozBusy = 1'b0;
      end else begin
        st_d.nozIdx = st_q.nozIdx + NOZZLE_FIRST;
      end
    end else if (stp.tick) begin // [R12]
      st_d.nozFire = 1'b1;
    end
  end

  always_ff @(posedge clock) begin
    if (!resetn) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign homeBusy = (st_q.hs == CHPS_HS_NUDGE) || (st_q.hs == CHPS_HS_FIND)
                    || (st_q.hs == CHPS_HS_CROSS);
  assign stp.run  = homeBusy || (st_q.pf == CHPS_PF_FEED) || st_q.nozBusy;

  always_comb begin
    case (st_q.hs)
      CHPS_HS_NUDGE: carriageDir = CHPS_CM_LEFT;
      CHPS_HS_FIND:  carriageDir = CHPS_CM_RIGHT;
      CHPS_HS_CROSS: carriageDir = CHPS_CM_RIGHT;
      default:       carriageDir = CHPS_CM_STOP; // [R10] [R11]
    endcase
  end

  assign feedRun       = (st_q.pf == CHPS_PF_FEED); // [R13]
  assign feedStep      = feedRun && stp.tick;
  assign carriageStep  = homeBusy && stp.tick;
  assign leadEdge      = st_q.leadEdge;
  assign trailEdge     = st_q.trailEdge;
  assign paperJam      = st_q.paperJam;
  assign homeFound     = st_q.homeFound;
  assign homeStuckHigh = st_q.stuckHigh;
  assign homeStuckLow  = st_q.stuckLow;
  assign nozzleFire    = st_q.nozFire;
  assign nozzleIndex   = st_q.nozIdx;
endmodule

//--- tb/chps_home_paper_properties.sv
// checker: port-level properties of chps_home_paper
// assumes it is bound onto every chps_home_paper instance
`timescale 1ns/1ps
module chps_home_paper_properties
  import chps_pkg::*;
(
  input wire logic                  clock,
  input wire logic                  resetn,
  input wire logic                  homeStart,
  input wire logic                  paperSense,
  input wire logic                  homeSense,
  input wire logic                  feedRun,
  input wire logic                  feedStep,
  input wire logic                  leadEdge,
  input wire logic                  trailEdge,
  input wire logic                  carriageStep,
  input wire chps_pkg::chps_cmove_e carriageDir,
  input wire logic                  homeFound,
  input wire logic                  homeBusy,
  input wire logic                  homeStuckHigh,
  input wire logic                  homeStuckLow,
  input wire logic                  nozzleFire,
  input wire logic [5:0]            nozzleIndex
);
  logic [5:0] lastIdx_q;
  default clocking cb @(posedge clock); endclocking
  default disable iff (!resetn);
  // ----
  // helpers
  // ----
  always_ff @(posedge clock) begin
    if (!resetn) lastIdx_q <= 6'h00;
    else if (nozzleFire)
      lastIdx_q <= (nozzleIndex == NOZZLE_LAST) ? 6'h00 : nozzleIndex;
  end
  sequence seqArm;
    homeStart && !homeBusy && !homeFound && !homeStuckHigh && !homeStuckLow;
  endsequence
  sequence seqNudge;
    homeBusy && carriageDir == CHPS_CM_LEFT;
  endsequence
  // ----
  // properties
  // ----
  lead_cause_a: assert property (
    leadEdge |-> $past(feedRun) && !$past(paperSense, 3))
    else $error("lead edge without feed and low sensor");
  lead_stop_a: assert property (
    leadEdge |=> !leadEdge && !feedRun) else $error("lead edge bad");
  trail_cause_a: assert property (
    trailEdge |-> $past(paperSense, 3) ##1 !trailEdge)
    else $error("trail edge bad");
  feed_step_a: assert property (
    feedStep |-> feedRun ##1 !feedStep) else $error("feed step bad");
  home_arm_a: assert property (
    seqArm |=> seqNudge) else $error("search did not start left");
  step_dir_a: assert property (
    carriageStep |-> carriageDir != CHPS_CM_STOP)
    else $error("carriage step without direction");
  fault_halt_a: assert property (
    homeStuckHigh || homeStuckLow |->
      carriageDir == CHPS_CM_STOP && !carriageStep && !homeBusy)
    else $error("carriage moving after fault");
  found_edge_a: assert property (
    $rose(homeFound) |-> $past(homeBusy) && !$past(homeSense, 3)
      && carriageDir == CHPS_CM_STOP) else $error("home found bad");
  nozzle_order_a: assert property (
    nozzleFire |-> nozzleIndex == lastIdx_q + 6'h01)
    else $error("nozzle out of order");
endmodule
bind chps_home_paper chps_home_paper_properties chk (
  .clock(clock), .resetn(resetn), .homeStart(homeStart),
  .paperSense(paperSense), .homeSense(homeSense), .feedRun(feedRun),
  .feedStep(feedStep), .leadEdge(leadEdge), .trailEdge(trailEdge),
  .carriageStep(carriageStep), .carriageDir(carriageDir),
  .homeFound(homeFound), .homeBusy(homeBusy),
  .homeStuckHigh(homeStuckHigh), .homeStuckLow(homeStuckLow),
  .nozzleFire(nozzleFire), .nozzleIndex(nozzleIndex));

//--- tb/chps_far_side.sv
// far side: paper lever sensor and carriage slit photointerrupter
// assumes one carriage step pulse per motor step
`timescale 1ns/1ps
module chps_far_side
  import chps_pkg::*;
#(
  parameter int START   = 40,
  parameter int SLIT_LO = 20,
  parameter int SLIT_HI = 27
)
(
  input  wire logic                  clock,
  input  wire logic                  sheetAtLever,
  input  wire logic                  carriageStep,
  input  wire chps_pkg::chps_cmove_e carriageDir,
  output logic                       paperSense,
  output logic                       homeSense
);
  int pos = START;
  // a sheet pushes the lever out of the beam, so the pin reads low
  assign paperSense = !sheetAtLever;
  always @(posedge clock) begin
    if (carriageStep) pos <= (carriageDir == CHPS_CM_LEFT) ? pos - 1 : pos + 1;
  end
  // slit in the beam reads high, open path low (home sits outside slit)
  assign homeSense = (pos >= SLIT_LO) && (pos <= SLIT_HI);
endmodule

//--- tb/chps_home_paper_tb.sv
// testbench: feed sensing, home search start, nozzle order
// assumes step period STEP_CYC; long counts are only partly walked
`timescale 1ns/1ps
module chps_home_paper_tb;
  import chps_pkg::*;
  logic clock = 1'b0, resetn, jobStart, bypassPresent, trayLoaded;
  logic sheetEject, homeStart, nozzleTestStart, sheetAtLever;
  logic paperSense, homeSense, feedRun, feedStep, leadEdge, trailEdge;
  logic paperJam, carriageStep, homeFound, homeBusy, nozzleFire;
  logic homeStuckHigh, homeStuckLow;
  logic [5:0] nozzleIndex;
  chps_cmove_e carriageDir;
  int failures = 0, n_tests = 0, seed = 32'h4181;
  logic [7:0] expQ[$];
  always #25 clock = ~clock;
  chps_home_paper dut (.clock(clock), .resetn(resetn), .jobStart(jobStart),
    .bypassPresent(bypassPresent), .trayLoaded(trayLoaded),
    .sheetEject(sheetEject), .homeStart(homeStart),
    .nozzleTestStart(nozzleTestStart), .paperSense(paperSense),
    .homeSense(homeSense), .feedRun(feedRun), .feedStep(feedStep),
    .leadEdge(leadEdge), .trailEdge(trailEdge), .paperJam(paperJam),
    .carriageStep(carriageStep), .carriageDir(carriageDir),
    .homeFound(homeFound), .homeBusy(homeBusy),
    .homeStuckHigh(homeStuckHigh), .homeStuckLow(homeStuckLow),
    .nozzleFire(nozzleFire), .nozzleIndex(nozzleIndex));
  chps_far_side far (.clock(clock), .sheetAtLever(sheetAtLever),
    .carriageStep(carriageStep), .carriageDir(carriageDir),
    .paperSense(paperSense), .homeSense(homeSense));
  // ----
  // shared tasks
  // ----
  task automatic cyc(input int n);
    repeat (n) @(posedge clock);
  endtask
  task automatic check(input logic [7:0] seen, input logic [7:0] want);
    n_tests++;
    if (seen !== want) begin
      failures++;
      $display("CHECK FAILED t=%0t seen=%h want=%h", $time, seen, want);
    end
  endtask
  task automatic take(input logic [7:0] seen);
    if (expQ.size() == 0) check(seen, 8'hff);
    else check(seen, expQ.pop_front());
  endtask
  task automatic print_verdict;
    $display("tests %0d failures %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  // ----
  // result monitor, off the launching edge
  // ----
  always @(negedge clock) begin
    if (leadEdge === 1'b1) take(8'h40);
    if (trailEdge === 1'b1) take(8'h80);
    if (nozzleFire === 1'b1) take({2'h3, nozzleIndex});
  end
  initial begin
    cyc(3 * STEP_CYC);
    failures++;
    print_verdict();
  end
  // ----
  // main sequence
  // ----
  initial begin
    {resetn, jobStart, bypassPresent, sheetEject} = 4'h0;
    {homeStart, nozzleTestStart, sheetAtLever, trayLoaded} = 4'h1;
    cyc(8);
    resetn <= 1'b1;
    cyc(4);
    for (int i = 0; i < 3; i++) begin
      {bypassPresent, trayLoaded} <= {i[1] | i[0], i[1]};
      jobStart <= 1'b1;
      cyc(1);
      jobStart <= 1'b0;
      cyc(2);
      @(negedge clock) check(8'(feedRun), 8'h00);
      cyc(1);
    end
    {bypassPresent, trayLoaded} <= 2'b01;
    jobStart <= 1'b1;
    cyc(1);
    jobStart <= 1'b0;
    @(negedge clock) check(8'(feedRun), 8'h01);
    cyc(($random(seed) & 15) + 2);
    expQ.push_back(8'h40);
    sheetAtLever <= 1'b1;
    cyc(12);
    check(8'(feedRun), 8'h00);
    check(8'(paperJam), 8'h00);
    sheetEject <= 1'b1;
    cyc(1);
    sheetEject <= 1'b0;
    expQ.push_back(8'h80);
    sheetAtLever <= 1'b0;
    cyc(12);
    check(8'(expQ.size()), 8'h00);
    for (int k = 1; k <= 3; k++) expQ.push_back(8'hc0 | 8'(k));
    {nozzleTestStart, homeStart} <= 2'b11;
    cyc(1);
    {nozzleTestStart, homeStart} <= 2'b00;
    cyc(2 * STEP_CYC + 100);
    check(8'(expQ.size()), 8'h01);
    check(8'(carriageDir), 8'(CHPS_CM_LEFT));
    // two step ticks have passed, so the carriage sits two places left
    check(8'(far.pos), 8'h26);
    check(8'({homeBusy, homeFound, homeStuckHigh, homeStuckLow}),
          8'h08);
    print_verdict();
  end
endmodule
